// file: src/lhp_pkg.sv
package lhp_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned WADDR_W = 16;

  // Host window map, byte addresses inside the 128K window
  localparam logic [16:0] BUF_BASE  = 17'h00000;
  localparam logic [16:0] BUF_LIMIT = 17'h14000;
  localparam logic [16:0] REG_BASE  = 17'h1FFE0;

  // Strap codes on {strap_2, strap_1, strap_0}
  localparam logic [2:0] STRAP_OTHER0  = 3'h0;
  localparam logic [2:0] STRAP_OTHER1  = 3'h1;
  localparam logic [2:0] STRAP_STROBE1 = 3'h3;
  localparam logic [2:0] STRAP_STROBE2 = 3'h5;
  localparam logic [2:0] STRAP_GENERIC = 3'h7;

  // Cycles after reset release before the straps are taken
  localparam logic [1:0] CFG_SETTLE = 2'h3;

  // Reset values of the host pins
  localparam logic WAIT_N_RST = 1'b1;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_OTHER0,
    MODE_OTHER1,
    MODE_STROBE1,
    MODE_STROBE2,
    MODE_GENERIC1,
    MODE_GENERIC2,
    MODE_RESERVED
  } lhp_mode_t;

  typedef enum logic [1:0] {
    TGT_BUF,
    TGT_REG,
    TGT_NONE
  } lhp_tgt_t;

endpackage

// file: src/lhp_xfer_if.sv
`timescale 1ns/1ps
interface lhp_xfer_if;
  logic                 req_tgl;
  logic                 ack_tgl;
  logic                 we;
  logic [1:0]           be;
  lhp_pkg::lhp_tgt_t    tgt;
  logic [15:0]          waddr;
  logic [15:0]          wdata;
  logic [15:0]          rdata;

  modport host (
    output req_tgl,
    output we,
    output be,
    output tgt,
    output waddr,
    output wdata,
    input  ack_tgl,
    input  rdata
  );

  modport sys (
    input  req_tgl,
    input  we,
    input  be,
    input  tgt,
    input  waddr,
    input  wdata,
    output ack_tgl,
    output rdata
  );
endinterface

// file: src/lhp_sync.sv
`timescale 1ns/1ps
module lhp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: src/lhp_sys_port.sv
`timescale 1ns/1ps
module lhp_sys_port (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  lhp_xfer_if.sys                   xfer,
  output logic                      mem_req,
  output logic                      mem_we,
  output logic [1:0]                mem_be,
  output logic                      mem_reg_sel,
  output logic [15:0]               mem_addr,
  output logic [15:0]               mem_wdata,
  input  wire logic [15:0]          mem_rdata,
  input  wire logic                 mem_ack
);
  typedef enum logic {S_IDLE, S_BUSY} lhp_sys_st_t;

  lhp_sys_st_t st_r;
  logic        req_s;
  logic        seen_r;
  logic        ack_r;
  logic [15:0] rdata_r;

  assign xfer.ack_tgl = ack_r;
  assign xfer.rdata   = rdata_r;

  lhp_sync #(.W(1)) u_req_sync (
    .clk  (clk_sys),
    .nrst (nrst),
    .d    (xfer.req_tgl),
    .q    (req_s)
  );

  // Payload is stable: host holds it until the answer toggles back
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r        <= S_IDLE;
      seen_r      <= 1'b0;
      ack_r       <= 1'b0;
      rdata_r     <= 16'h0000;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_be      <= 2'h0;
      mem_reg_sel <= 1'b0;
      mem_addr    <= 16'h0000;
      mem_wdata   <= 16'h0000;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          if (req_s != seen_r)
          begin
            seen_r <= req_s;
            if (xfer.tgt == lhp_pkg::TGT_NONE)
            begin
              // Outside the window: writes dropped, reads give zero
              rdata_r <= 16'h0000;
              ack_r   <= ~ack_r;
            end
            else
            begin
              mem_req     <= 1'b1;
              mem_we      <= xfer.we;
              mem_be      <= xfer.be;
              mem_reg_sel <= (xfer.tgt == lhp_pkg::TGT_REG);
              mem_addr    <= xfer.waddr;
              mem_wdata   <= xfer.wdata;
              st_r        <= S_BUSY;
            end
          end
        end
        S_BUSY:
        begin
          // Arbiter against refresh decides how long this takes
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            rdata_r <= mem_we ? rdata_r : mem_rdata;
            ack_r   <= ~ack_r;
            st_r    <= S_IDLE;
          end
        end
        default:
        begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: src/lhp_host_port.sv
`timescale 1ns/1ps
module lhp_host_port (
  input  wire logic                 clk_sys,
  input  wire logic                 host_bus_clock,
  input  wire logic                 nrst,
  input  wire logic                 cs_n,
  input  wire logic                 address_bit0,
  input  wire logic [16:1]          word_address,
  input  wire logic [15:0]          data_in,
  output logic      [15:0]          data_out,
  output logic                      data_oe,
  input  wire logic                 bus_status_n,
  input  wire logic                 rd_wr_n,
  input  wire logic                 rd_n,
  input  wire logic                 low_byte_write_n,
  input  wire logic                 high_byte_strobe_n,
  output logic                      wait_n,
  output logic                      wait_oe,
  input  wire logic                 bus_select_strap_0,
  input  wire logic                 bus_select_strap_1,
  input  wire logic                 bus_select_strap_2,
  input  wire logic                 endian_strap,
  output lhp_pkg::lhp_mode_t        bus_mode,
  output logic                      big_endian,
  output logic                      cfg_valid,
  output logic                      mem_req,
  output logic                      mem_we,
  output logic [1:0]                mem_be,
  output logic                      mem_reg_sel,
  output logic [15:0]               mem_addr,
  output logic [15:0]               mem_wdata,
  input  wire logic [15:0]          mem_rdata,
  input  wire logic                 mem_ack
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_DONE, H_PARK} lhp_host_st_t;

  localparam int unsigned PIN_W = 43;

  lhp_xfer_if xfer ();

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;

  logic        cs_s;
  logic        a0_s;
  logic [15:0] wa_s;
  logic [15:0] d_s;
  logic        bs_s;
  logic        rw_s;
  logic        rd_s;
  logic        we0_s;
  logic        hbs_s;
  logic [3:0]  strap_s;
  logic        ack_s;

  lhp_host_st_t st_r;
  logic [1:0]  cfg_cnt_r;
  logic        ack_seen_r;
  logic        req_r;
  logic        we_r;
  logic [1:0]  be_r;
  lhp_pkg::lhp_tgt_t tgt_r;
  logic [15:0] waddr_r;
  logic [15:0] wdata_r;

  logic        cyc_act;
  logic        cyc_we;
  logic [1:0]  cyc_be;
  logic [16:0] byte_addr;
  lhp_pkg::lhp_tgt_t cyc_tgt;
  logic        strobe_mode;
  logic        ready_lvl;
  logic        ack_new;
  logic [15:0] rd_swap;

  // Every pin into this domain passes two flops first
  assign pin_raw = {cs_n, address_bit0, word_address, data_in, bus_status_n, rd_wr_n,
                    rd_n, low_byte_write_n, high_byte_strobe_n, endian_strap,
                    bus_select_strap_2, bus_select_strap_1, bus_select_strap_0};

  lhp_sync #(.W(PIN_W)) u_pin_sync (
    .clk  (host_bus_clock),
    .nrst (nrst),
    .d    (pin_raw),
    .q    (pin_s)
  );

  lhp_sync #(.W(1)) u_ack_sync (
    .clk  (host_bus_clock),
    .nrst (nrst),
    .d    (xfer.ack_tgl),
    .q    (ack_s)
  );

  assign {cs_s, a0_s, wa_s, d_s, bs_s, rw_s, rd_s, we0_s, hbs_s, strap_s} = pin_s;

  assign xfer.req_tgl = req_r;
  assign xfer.we      = we_r;
  assign xfer.be      = be_r;
  assign xfer.tgt     = tgt_r;
  assign xfer.waddr   = waddr_r;
  assign xfer.wdata   = wdata_r;

  lhp_sys_port u_sys (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .xfer        (xfer.sys),
    .mem_req     (mem_req),
    .mem_we      (mem_we),
    .mem_be      (mem_be),
    .mem_reg_sel (mem_reg_sel),
    .mem_addr    (mem_addr),
    .mem_wdata   (mem_wdata),
    .mem_rdata   (mem_rdata),
    .mem_ack     (mem_ack)
  );

  // Straps taken a few edges after release, once the sync chain holds them
  always_ff @(posedge host_bus_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_cnt_r  <= 2'h0;
      cfg_valid  <= 1'b0;
      bus_mode   <= lhp_pkg::MODE_RESERVED;
      big_endian <= 1'b0;
    end
    else if (!cfg_valid)
    begin
      cfg_cnt_r <= cfg_cnt_r + 2'h1;
      if (cfg_cnt_r == lhp_pkg::CFG_SETTLE)
      begin
        cfg_valid  <= 1'b1;
        big_endian <= strap_s[3];
        case (strap_s[2:0])
          lhp_pkg::STRAP_OTHER0:  bus_mode <= lhp_pkg::MODE_OTHER0;
          lhp_pkg::STRAP_OTHER1:  bus_mode <= lhp_pkg::MODE_OTHER1;
          lhp_pkg::STRAP_STROBE1: bus_mode <= lhp_pkg::MODE_STROBE1;
          lhp_pkg::STRAP_STROBE2: bus_mode <= lhp_pkg::MODE_STROBE2;
          lhp_pkg::STRAP_GENERIC:
            bus_mode <= bs_s ? lhp_pkg::MODE_GENERIC2 : lhp_pkg::MODE_GENERIC1;
          default:                bus_mode <= lhp_pkg::MODE_RESERVED;
        endcase
      end
    end
  end

  assign strobe_mode = (bus_mode == lhp_pkg::MODE_STROBE1) ||
                       (bus_mode == lhp_pkg::MODE_STROBE2);
  // Strobe modes use the pin as an acknowledge, generic modes as a wait
  assign ready_lvl   = strobe_mode ? 1'b0 : 1'b1;
  assign ack_new     = (ack_s != ack_seen_r);

  // Cycle decode per latched mode
  always_comb
  begin
    cyc_act = 1'b0;
    cyc_we  = 1'b0;
    cyc_be  = 2'h0;
    case (bus_mode)
      lhp_pkg::MODE_STROBE1,
      lhp_pkg::MODE_STROBE2:
      begin
        // Low write and read enables are ignored here
        cyc_act = !cs_s && !bs_s && (!a0_s || !hbs_s);
        cyc_we  = !rw_s;
        cyc_be  = {!hbs_s, !a0_s};
      end
      lhp_pkg::MODE_GENERIC1:
      begin
        cyc_act = !cs_s && (!we0_s || !hbs_s || !rd_s || !rw_s);
        cyc_we  = !we0_s || !hbs_s;
        cyc_be  = cyc_we ? {!hbs_s, !we0_s} : {!rw_s, !rd_s};
      end
      lhp_pkg::MODE_GENERIC2:
      begin
        cyc_act = !cs_s && (!rd_s || !we0_s) && (!a0_s || !hbs_s);
        cyc_we  = !we0_s;
        cyc_be  = {!hbs_s, !a0_s};
      end
      default:
      begin
        cyc_act = 1'b0;
      end
    endcase
  end

  // Window map: buffer from base, registers in the top bytes
  assign byte_addr = {wa_s, 1'b0};
  always_comb
  begin
    if (byte_addr >= lhp_pkg::REG_BASE)
      cyc_tgt = lhp_pkg::TGT_REG;
    else if (byte_addr < lhp_pkg::BUF_LIMIT)
      cyc_tgt = lhp_pkg::TGT_BUF;
    else
      cyc_tgt = lhp_pkg::TGT_NONE;
  end

  assign rd_swap = big_endian ? {xfer.rdata[7:0], xfer.rdata[15:8]} : xfer.rdata;

  // Host cycle sequencing
  always_ff @(posedge host_bus_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r       <= H_IDLE;
      ack_seen_r <= 1'b0;
      req_r      <= 1'b0;
      we_r       <= 1'b0;
      be_r       <= 2'h0;
      tgt_r      <= lhp_pkg::TGT_NONE;
      waddr_r    <= 16'h0000;
      wdata_r    <= 16'h0000;
    end
    else
    begin
      case (st_r)
        H_IDLE:
        begin
          if (cfg_valid && cyc_act)
          begin
            we_r    <= cyc_we;
            be_r    <= big_endian ? {cyc_be[0], cyc_be[1]} : cyc_be;
            tgt_r   <= cyc_tgt;
            waddr_r <= wa_s;
            wdata_r <= big_endian ? {d_s[7:0], d_s[15:8]} : d_s;
            req_r   <= ~req_r;
            st_r    <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          if (ack_new)
          begin
            ack_seen_r <= ack_s;
            st_r       <= H_DONE;
          end
        end
        H_DONE:
        begin
          if (!cyc_act)
          begin
            st_r <= H_PARK;
          end
        end
        H_PARK:
        begin
          st_r <= H_IDLE;
        end
        default:
        begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // Wait pin: driven from cycle start until answered and deselected, parked inactive one cycle before release
  always_ff @(posedge host_bus_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_n  <= lhp_pkg::WAIT_N_RST;
      wait_oe <= 1'b0;
    end
    else
    begin
      case (st_r)
        H_IDLE:
        begin
          wait_oe <= cfg_valid && cyc_act;
          wait_n  <= cyc_act ? ~ready_lvl : lhp_pkg::WAIT_N_RST;
        end
        H_WAIT:
        begin
          wait_oe <= 1'b1;
          wait_n  <= ack_new ? ready_lvl : ~ready_lvl;
        end
        H_DONE:
        begin
          // Acknowledge line is shared, so never leave it floating low
          wait_oe <= 1'b1;
          wait_n  <= cyc_act ? ready_lvl : lhp_pkg::WAIT_N_RST;
        end
        default:
        begin
          wait_oe <= 1'b0;
          wait_n  <= lhp_pkg::WAIT_N_RST;
        end
      endcase
    end
  end

  // Read data driven from the answer until the strobes drop
  always_ff @(posedge host_bus_clock or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= lhp_pkg::DATA_RST;
      data_oe  <= 1'b0;
    end
    else if (st_r == H_WAIT && ack_new && !we_r)
    begin
      data_out <= rd_swap;
      data_oe  <= 1'b1;
    end
    else if (st_r == H_DONE && cyc_act)
    begin
      data_oe <= data_oe;
    end
    else
    begin
      data_oe <= 1'b0;
    end
  end
endmodule

// file: tb/lhp_host_port_props.sv
`timescale 1ns/1ps
module lhp_host_port_props (
  input wire logic               clk_sys,
  input wire logic               host_bus_clock,
  input wire logic               nrst,
  input wire logic               cs_n,
  input wire logic               wait_n,
  input wire logic               wait_oe,
  input wire logic               data_oe,
  input wire lhp_pkg::lhp_mode_t bus_mode,
  input wire logic               big_endian,
  input wire logic               cfg_valid,
  input wire logic               mem_req,
  input wire logic               mem_ack,
  input wire logic               mem_reg_sel,
  input wire logic [15:0]        mem_addr,
  input wire logic [15:0]        mem_wdata
);
  // Strobe modes answer with acknowledge sense, generic modes with wait sense
  wire stb = (bus_mode == lhp_pkg::MODE_STROBE1) || (bus_mode == lhp_pkg::MODE_STROBE2);

  a_busy_level: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    $rose(wait_oe) |-> wait_n == stb) else $error("wait pin not at busy level");
  a_ready_level: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    $rose(data_oe) |-> wait_n == !stb) else $error("read data without ready level");
  a_data_in_cycle: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    data_oe |-> wait_oe) else $error("data driven outside a cycle");
  a_wait_parked: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    cs_n [*7] |-> !wait_oe) else $error("wait pin still driven while deselected");
  a_park_high: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    $fell(wait_oe) |-> $past(wait_n)) else $error("wait pin released without park");
  a_cfg_quiet: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    !cfg_valid |-> !wait_oe && !data_oe) else $error("pins driven before straps taken");
  a_cfg_hold: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    cfg_valid && $past(cfg_valid) |-> $stable(bus_mode) && $stable(big_endian))
    else $error("latched mode changed");
  a_no_response: assert property (@(posedge host_bus_clock) disable iff (!nrst)
    bus_mode inside {lhp_pkg::MODE_OTHER0, lhp_pkg::MODE_OTHER1, lhp_pkg::MODE_RESERVED}
    |-> !wait_oe) else $error("unsupported mode answered");
  a_mem_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("request changed before ack");
  a_req_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_req && mem_ack |=> !mem_req) else $error("request held after ack");
  a_window_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    mem_req |-> mem_reg_sel || mem_addr < 16'hA000) else $error("request into window hole");

  c_strobe_read: cover property (@(posedge host_bus_clock) disable iff (!nrst)
    stb && $rose(data_oe));
  c_reg_access: cover property (@(posedge clk_sys) disable iff (!nrst)
    mem_req && mem_ack && mem_reg_sel);
  c_generic_two: cover property (@(posedge host_bus_clock) disable iff (!nrst)
    $rose(cfg_valid) && bus_mode == lhp_pkg::MODE_GENERIC2);
endmodule

bind lhp_host_port lhp_host_port_props props (.clk_sys, .host_bus_clock, .nrst, .cs_n,
  .wait_n, .wait_oe, .data_oe, .bus_mode, .big_endian, .cfg_valid, .mem_req, .mem_ack,
  .mem_reg_sel, .mem_addr, .mem_wdata);

// file: tb/lhp_mem_model.sv
`timescale 1ns/1ps
module lhp_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_be,
  input  wire logic        mem_reg_sel,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  dly,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] m [logic [16:0]];
  logic [3:0]  cnt_r;
  logic [15:0] old;
  wire  [16:0] key = {mem_reg_sel, mem_addr};

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h5A5A;
    end
    else
    begin
      // Read lines toggle when idle so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack)
      begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r >= dly)
        begin
          cnt_r <= 4'h0;
          mem_ack <= 1'b1;
          old = m.exists(key) ? m[key] : 16'h0000;
          if (mem_we)
            m[key] = {mem_be[1] ? mem_wdata[15:8] : old[15:8],
                      mem_be[0] ? mem_wdata[7:0] : old[7:0]};
          else
            mem_rdata <= old;
        end
      end
    end
  end
endmodule

// file: tb/lhp_host_port_test.sv
`timescale 1ns/1ps
module lhp_host_port_test;
  logic clk_sys = 1'b0, host_bus_clock = 1'b0, nrst = 1'b0, gen = 1'b1, g2 = 1'b0;
  logic cs_n = 1'b1, address_bit0 = 1'b1, bus_status_n = 1'b0, rd_wr_n = 1'b1;
  logic rd_n = 1'b1, low_byte_write_n = 1'b1, high_byte_strobe_n = 1'b1;
  logic [16:1] word_address = 16'h0000;
  logic [15:0] data_in = 16'h0000, data_out, mem_addr, mem_wdata, mem_rdata;
  logic [3:0]  strap = 4'h0, dly = 4'h0;
  logic        data_oe, wait_n, wait_oe, big_endian, cfg_valid, doe_q = 1'b0, cfg_q = 1'b0;
  logic        mem_req, mem_we, mem_reg_sel, mem_ack;
  logic [1:0]  mem_be;
  lhp_pkg::lhp_mode_t bus_mode;
  logic [15:0] expq [$];
  logic [31:0] seed = 32'h0000_0020;
  int          fails = 0;
  int          comparisons = 0;

  // Pulled-up wait line, and the select-gated inverter of a generic host
  wire wait_line = wait_oe ? wait_n : 1'b1;
  wire glue_wait = !cs_n && !wait_line;

  always #2.5 clk_sys = ~clk_sys;
  always #24 host_bus_clock = ~host_bus_clock;

  lhp_host_port dut (.clk_sys, .host_bus_clock, .nrst, .cs_n, .address_bit0, .word_address,
    .data_in, .data_out, .data_oe, .bus_status_n, .rd_wr_n, .rd_n, .low_byte_write_n,
    .high_byte_strobe_n, .wait_n, .wait_oe, .bus_select_strap_0(strap[0]),
    .bus_select_strap_1(strap[1]), .bus_select_strap_2(strap[2]), .endian_strap(strap[3]),
    .bus_mode, .big_endian, .cfg_valid, .mem_req, .mem_we, .mem_be, .mem_reg_sel, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);
  lhp_mem_model mdl (.clk_sys, .nrst, .mem_req, .mem_we, .mem_be, .mem_reg_sel, .mem_addr,
    .mem_wdata, .dly, .mem_rdata, .mem_ack);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic lhp_pkg::lhp_mode_t dec(input logic [2:0] s, input logic bs);
    case (s)
      3'h0: return lhp_pkg::MODE_OTHER0;
      3'h1: return lhp_pkg::MODE_OTHER1;
      3'h3: return lhp_pkg::MODE_STROBE1;
      3'h5: return lhp_pkg::MODE_STROBE2;
      3'h7: return bs ? lhp_pkg::MODE_GENERIC2 : lhp_pkg::MODE_GENERIC1;
      default: return lhp_pkg::MODE_RESERVED;
    endcase
  endfunction

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task test_done;
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task rst(input logic [3:0] s, input logic bs);
    nrst <= 1'b0;
    strap <= s;
    bus_status_n <= bs;
    repeat (2) @(posedge host_bus_clock);
    expq.push_back({12'h000, dec(s[2:0], bs), s[3]});
    nrst <= 1'b1;
    for (int n = 0; n < 20 && cfg_valid !== 1'b1; n++) @(posedge host_bus_clock);
    if (cfg_valid !== 1'b1) chk(16'h0001, 16'h0000);
    if (cfg_valid !== 1'b1) test_done();
  endtask

  // Generic mode one uses split enables, strobe mode one a direction line
  task cyc(input logic we, input logic [1:0] be, input logic [16:0] a, input logic [15:0] d);
    int n;
    @(posedge host_bus_clock);
    dly <= 4'(rnd());
    cs_n <= 1'b0;
    word_address <= a[16:1];
    data_in <= d;
    address_bit0 <= (gen && !g2) ? a[0] : !be[0];
    high_byte_strobe_n <= (gen && !g2) ? !(we && be[1]) : !be[1];
    low_byte_write_n <= !(gen && we && (g2 || be[0]));
    rd_n <= !(gen && !we && (g2 || be[0]));
    rd_wr_n <= (gen && !g2) ? !(!we && be[1]) : !we;
    bus_status_n <= 1'b0;
    for (n = 0; n < 300; n++)
    begin
      @(posedge host_bus_clock);
      if (wait_oe === 1'b1 && (gen ? glue_wait === 1'b0 : wait_line === 1'b0)) break;
    end
    if (n == 300) chk(16'h0001, 16'h0000);
    if (n == 300) test_done();
    {cs_n, rd_n, rd_wr_n, low_byte_write_n, high_byte_strobe_n} <= 5'h1F;
    bus_status_n <= !gen;
    data_in <= ~d;
    repeat (6) @(posedge host_bus_clock);
  endtask

  task suite;
    logic [16:0] a;
    logic [15:0] d;
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 3) ? 17'h13FFE : 17'((rnd() % 32'h0000_A000) << 1);
      d = 16'(rnd());
      cyc(1'b1, 2'h3, a, d);
      chk(strap[3] ? {d[7:0], d[15:8]} : d, mdl.m[{1'b0, a[16:1]}]);
      cyc(1'b1, 2'h1, a, 16'h5AC5);
      expq.push_back({d[15:8], 8'hC5});
      cyc(1'b0, 2'h3, a, 16'h0000);
    end
    cyc(1'b1, 2'h3, 17'h15000, 16'hBEEF);
    expq.push_back(16'h0000);
    cyc(1'b0, 2'h3, 17'h15000, 16'h0000);
    d = 16'(rnd());
    cyc(1'b1, 2'h3, 17'h1FFE2, d);
    expq.push_back(d);
    cyc(1'b0, 2'h3, 17'h1FFE2, 16'h0000);
  endtask

  always @(posedge host_bus_clock)
  begin
    if (data_oe === 1'b1 && doe_q !== 1'b1) chk(expq.pop_front(), data_out);
    if (cfg_valid === 1'b1 && cfg_q !== 1'b1)
      chk(expq.pop_front(), {12'h000, bus_mode, big_endian});
    doe_q <= data_oe;
    cfg_q <= cfg_valid;
  end

  initial
  begin
    for (int i = 0; i < 16; i++) rst(4'(i), i[0] ^ i[3]);
    rst(4'h2, 1'b0);
    {cs_n, address_bit0, rd_n, rd_wr_n, low_byte_write_n, high_byte_strobe_n} <= 6'h00;
    repeat (8) @(posedge host_bus_clock);
    chk(16'h0000, {15'h0000, wait_oe | data_oe});
    {cs_n, address_bit0, rd_n, rd_wr_n, low_byte_write_n, high_byte_strobe_n} <= 6'h3F;
    gen = 1'b1;
    rst(4'h7, 1'b0);
    suite();
    gen = 1'b0;
    rst(4'hB, 1'b1);
    suite();
    rst(4'hD, 1'b0);
    suite();
    gen = 1'b1;
    g2 = 1'b1;
    rst(4'h7, 1'b1);
    suite();
    test_done();
  end
endmodule
